// ---- common/home_return_defines.svh ----
// register map, field positions, error codes and reset values for the homing sequencer
`ifndef HOME_RETURN_DEFINES_SVH
`define HOME_RETURN_DEFINES_SVH
`define REG_CTRL         8'h00
`define REG_STATUS       8'h04
`define REG_ERROR        8'h08
`define REG_HOME_POS     8'h0C
`define REG_CUR_POS      8'h10
`define CTRL_MODE_LSB    0
`define CTRL_MODE_MSB    1
`define CTRL_DIR_NEG     2
`define CTRL_Z_SET       3
`define CTRL_LIM_CFG     4
`define CTRL_START       8
`define CTRL_ERR_CLR     9
`define ERR_NONE         16'h0000
`define ERR_ALREADY_DONE 16'h0073
`define ERR_NO_ZERO      16'h0078
`define ERR_HOME_IN_DOG  16'h007B
`define ERR_Z_SETTING    16'h007C
`define ERR_NO_LIMIT_CFG 16'h008E
`define ERR_NO_DOG       16'h00C9
`define ERR_LIMIT_UP     16'h044D
`define ERR_LIMIT_LOW    16'h044E
`define POS_RESET        32'h0000_0000
`define WORD_ZERO        32'h0000_0000
`endif

// ---- common/home_return_pkg.sv ----
// types shared by the homing sequencer
package home_return_pkg;
   typedef enum logic [1:0] {MODE_STOPPER1, MODE_STOPPER2, MODE_LIMIT, MODE_SCALE} mode_t;
   typedef enum logic [1:0] {SPD_STOP, SPD_CREEP, SPD_RETURN} speed_t;
   typedef enum {
      ST_IDLE, ST_S_FAST, ST_S_CREEP, ST_L_FAST, ST_L_STOP, ST_L_CREEP,
      ST_C_FAST, ST_C_STOP1, ST_C_REV, ST_C_STOP2, ST_C_CREEP, ST_SETTLE, ST_HALT
   } state_t;
endpackage

// ---- hw/home_return_sequencer.sv ----
// homing sequencer: stopper 1/2, limit switch combined and scale home signal methods
// Function
// - stopper 1: return speed, creep from dog on, creep torque limit at creep speed
// - stopper types: motor position at torque-limiting rising edge becomes home
// - stopper types need no zero point passed since power-up
// - no retry function in any of these four methods
// - stopper types: request after completion refused, minor error 115
// - stopper 1 started with dog active begins directly at creep speed
// - stopper 2: creep speed and creep torque limit from the very start
// - limit mode: fast until return limit goes off, reverse at creep, zero is home
// - limit mode without configured limit inputs refused, minor error 142
// - limit mode: opposite limit on-to-off stops, homing incomplete, major 1101/1102
// - limit mode started with limit already off moves reverse at creep
// - limit mode: no zero passed before limit stop gives minor 120 unless setting 1
// - scale mode: reverse after dog, detected home signal position is home
// - scale mode: home inside dog and request after completion gives minor 123
// - scale mode: z-phase setting 1 at start refused, minor error 124
// - scale mode: zero crossing flag clears at reverse start, sets at next zero
// - scale mode in dog: reverse, stop at home signal, creep back, signal is home
// - scale mode: zero passed in deceleration, nearest signal in return direction used
// - scale mode: error when no dog lies in the return direction
// - homing not complete until the servo settled flag is active
//
// Implementation choices: register access over Avalon-MM and the placing of the registers.
`include "home_return_defines.svh"
module home_return_sequencer
   import home_return_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        SYS_RST,
   input  wire logic [7:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   output logic      [31:0] AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   input  wire logic        DOG,
   input  wire logic        LIMIT_UP,
   input  wire logic        LIMIT_LOW,
   input  wire logic        ZERO_PULSE,
   input  wire logic        TORQUE_LIMITING,
   input  wire logic        AT_SPEED,
   input  wire logic        STOPPED,
   input  wire logic        SERVO_SETTLED,
   input  wire logic [31:0] MOTOR_POS,
   output logic      [1:0]  SPEED_SEL,
   output logic             DIR_NEG,
   output logic             TORQUE_LIMIT_EN
);

   state_t      state;
   mode_t       mode;
   logic        ret_neg;
   logic        z_set;
   logic        lim_cfg;
   logic        done;
   logic        home_in_dog;
   logic        zero_crossing_flag;
   logic        zero_seen;
   logic        rev_begin;
   logic [15:0] minor_code;
   logic [15:0] major_code;
   logic [31:0] home_pos;
   logic [31:0] cur_pos;
   logic        dog_q;
   logic        torque_q;
   logic        up_q;
   logic        low_q;
   logic        bus_wr;
   logic        start_req;
   logic        err_clr;
   logic [15:0] start_err;
   logic        accept;
   logic        ret_lim;
   logic        ret_lim_q;
   logic        opp_fall;

   // read mux; unmapped addresses read as zero
   function automatic logic [31:0] read_word(input logic [7:0] a);
      logic [31:0] w;
      w = `WORD_ZERO;
      case (a)
         `REG_CTRL:     w = {27'h0, lim_cfg, z_set, ret_neg, mode};
         `REG_STATUS:   w = {28'h0, home_in_dog, zero_crossing_flag, done,
                             state != ST_IDLE};
         `REG_ERROR:    w = {major_code, minor_code};
         `REG_HOME_POS: w = home_pos;
         `REG_CUR_POS:  w = cur_pos;
         default:       w = `WORD_ZERO;
      endcase
      return w;
   endfunction

   // refusal code for a new request, checked only while idle
   function automatic logic [15:0] check_start(input mode_t m, input logic d,
                                               input logic in_dog, input logic cfg,
                                               input logic zs);
      logic [15:0] e;
      e = `ERR_NONE;
      case (m)
         MODE_STOPPER1, MODE_STOPPER2: if (d) e = `ERR_ALREADY_DONE;
         MODE_LIMIT:   if (!cfg) e = `ERR_NO_LIMIT_CFG;
         MODE_SCALE: begin
            if (zs)
               e = `ERR_Z_SETTING;
            else if (d && in_dog)
               e = `ERR_HOME_IN_DOG;
         end
         default:      e = `ERR_NONE;
      endcase
      return e;
   endfunction

   // bus decode; a write takes effect at the edge where waitrequest is low
   assign bus_wr    = AVS_WRITE && !AVS_WAITREQUEST && (AVS_ADDRESS == `REG_CTRL);
   assign start_req = bus_wr && AVS_WRITEDATA[`CTRL_START];
   assign err_clr   = bus_wr && AVS_WRITEDATA[`CTRL_ERR_CLR];
   assign start_err = check_start(mode, done, home_in_dog, lim_cfg, z_set);
   assign accept    = start_req && (state == ST_IDLE) && (start_err == `ERR_NONE);
   assign ret_lim   = ret_neg ? LIMIT_LOW : LIMIT_UP;
   assign opp_fall  = ret_neg ? (up_q && !LIMIT_UP) : (low_q && !LIMIT_LOW);

   // one wait state per access, then the answer; read data loaded with it
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         AVS_WAITREQUEST <= 1'b1;
         AVS_READDATA    <= `WORD_ZERO;
      end else if ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST) begin
         AVS_WAITREQUEST <= 1'b0;
         AVS_READDATA    <= AVS_READ ? read_word(AVS_ADDRESS) : `WORD_ZERO;
      end else begin
         AVS_WAITREQUEST <= 1'b1;
      end
   end

   // configuration held while a sequence runs so the method cannot change mid-way
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         mode    <= MODE_STOPPER1;
         ret_neg <= 1'b0;
         z_set   <= 1'b0;
         lim_cfg <= 1'b0;
      end else if (bus_wr && state == ST_IDLE) begin
         mode    <= mode_t'(AVS_WRITEDATA[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
         ret_neg <= AVS_WRITEDATA[`CTRL_DIR_NEG];
         z_set   <= AVS_WRITEDATA[`CTRL_Z_SET];
         lim_cfg <= AVS_WRITEDATA[`CTRL_LIM_CFG];
      end
   end

   // previous input levels for edge detection
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         dog_q     <= 1'b0;
         torque_q  <= 1'b0;
         up_q      <= 1'b0;
         low_q     <= 1'b0;
         ret_lim_q <= 1'b0;
      end else begin
         dog_q     <= DOG;
         torque_q  <= TORQUE_LIMITING;
         up_q      <= LIMIT_UP;
         low_q     <= LIMIT_LOW;
         ret_lim_q <= ret_lim;
      end
   end

   // zero crossing flag; setting 1 forces it on, a passage wins over the clear
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST)
         zero_crossing_flag <= 1'b0;
      else if (ZERO_PULSE || z_set)
         zero_crossing_flag <= 1'b1;
      else if (rev_begin)
         zero_crossing_flag <= 1'b0;
   end

   // zero passed since this sequence started
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST)
         zero_seen <= 1'b0;
      else if (ZERO_PULSE)
         zero_seen <= 1'b1;
      else if (accept)
         zero_seen <= 1'b0;
   end

   // sequencer; errors end the run in idle, nothing restarts it on its own
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         state           <= ST_IDLE;
         SPEED_SEL       <= SPD_STOP;
         DIR_NEG         <= 1'b0;
         TORQUE_LIMIT_EN <= 1'b0;
         done            <= 1'b0;
         home_in_dog     <= 1'b0;
         rev_begin       <= 1'b0;
         minor_code      <= `ERR_NONE;
         major_code      <= `ERR_NONE;
         home_pos        <= `POS_RESET;
         cur_pos         <= `POS_RESET;
      end else begin
         rev_begin <= 1'b0;
         if (err_clr) begin
            minor_code <= `ERR_NONE;
            major_code <= `ERR_NONE;
         end
         case (state)
            ST_IDLE: begin
               SPEED_SEL       <= SPD_STOP;
               TORQUE_LIMIT_EN <= 1'b0;
               if (start_req && start_err != `ERR_NONE)
                  minor_code <= start_err;
               if (accept) begin
                  done    <= 1'b0;
                  DIR_NEG <= ret_neg;
                  case (mode)
                     MODE_STOPPER1: begin
                        // no zero check in stopper types
                        if (DOG) begin
                           SPEED_SEL <= SPD_CREEP;
                           state     <= ST_S_CREEP;
                        end else begin
                           SPEED_SEL <= SPD_RETURN;
                           state     <= ST_S_FAST;
                        end
                     end
                     MODE_STOPPER2: begin
                        SPEED_SEL       <= SPD_CREEP;
                        TORQUE_LIMIT_EN <= 1'b1;
                        state           <= ST_S_CREEP;
                     end
                     MODE_LIMIT: begin
                        if (ret_lim) begin
                           SPEED_SEL <= SPD_RETURN;
                           state     <= ST_L_FAST;
                        end else begin
                           SPEED_SEL <= SPD_CREEP;
                           DIR_NEG   <= !ret_neg;
                           state     <= ST_L_CREEP;
                        end
                     end
                     default: begin
                        SPEED_SEL <= SPD_RETURN;
                        if (DOG) begin
                           DIR_NEG   <= !ret_neg;
                           rev_begin <= 1'b1;
                           state     <= ST_C_REV;
                        end else begin
                           state <= ST_C_FAST;
                        end
                     end
                  endcase
               end
            end
            ST_S_FAST: begin
               if (DOG && !dog_q) begin
                  SPEED_SEL <= SPD_CREEP;
                  state     <= ST_S_CREEP;
               end
            end
            ST_S_CREEP: begin
               if (AT_SPEED)
                  TORQUE_LIMIT_EN <= 1'b1;
               if (TORQUE_LIMIT_EN && TORQUE_LIMITING && !torque_q) begin
                  home_pos  <= MOTOR_POS;
                  SPEED_SEL <= SPD_STOP;
                  state     <= ST_SETTLE;
               end
            end
            ST_L_FAST: begin
               if (!ret_lim && ret_lim_q) begin
                  SPEED_SEL <= SPD_STOP;
                  state     <= ST_L_STOP;
               end
            end
            ST_L_STOP: begin
               if (STOPPED) begin
                  if (!zero_seen && !z_set) begin
                     minor_code <= `ERR_NO_ZERO;
                     state      <= ST_IDLE;
                  end else begin
                     SPEED_SEL <= SPD_CREEP;
                     DIR_NEG   <= !ret_neg;
                     state     <= ST_L_CREEP;
                  end
               end
            end
            ST_L_CREEP: begin
               // first zero met going back is the last one before the switch
               if (ZERO_PULSE) begin
                  home_pos  <= MOTOR_POS;
                  SPEED_SEL <= SPD_STOP;
                  state     <= ST_SETTLE;
               end
            end
            ST_C_FAST: begin
               if (DOG && !dog_q) begin
                  SPEED_SEL <= SPD_STOP;
                  state     <= ST_C_STOP1;
               end else if (!ret_lim && ret_lim_q) begin
                  minor_code <= `ERR_NO_DOG;
                  SPEED_SEL  <= SPD_STOP;
                  state      <= ST_HALT;
               end
            end
            ST_C_STOP1: begin
               if (STOPPED) begin
                  SPEED_SEL <= SPD_RETURN;
                  DIR_NEG   <= !ret_neg;
                  rev_begin <= 1'b1;
                  state     <= ST_C_REV;
               end
            end
            ST_C_REV: begin
               if (ZERO_PULSE) begin
                  SPEED_SEL <= SPD_STOP;
                  state     <= ST_C_STOP2;
               end
            end
            ST_C_STOP2: begin
               // zeros passed while stopping are ignored here
               if (STOPPED) begin
                  SPEED_SEL <= SPD_CREEP;
                  DIR_NEG   <= ret_neg;
                  state     <= ST_C_CREEP;
               end
            end
            ST_C_CREEP: begin
               // nearest signal in the return direction from the stop point
               if (ZERO_PULSE) begin
                  home_pos    <= MOTOR_POS;
                  home_in_dog <= DOG;
                  SPEED_SEL   <= SPD_STOP;
                  state       <= ST_SETTLE;
               end
            end
            ST_SETTLE: begin
               if (STOPPED && SERVO_SETTLED) begin
                  done            <= 1'b1;
                  cur_pos         <= home_pos;
                  TORQUE_LIMIT_EN <= 1'b0;
                  state           <= ST_IDLE;
               end
            end
            ST_HALT: begin
               if (STOPPED)
                  state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
         // opposite limit released during a limit-mode run aborts it
         if (opp_fall && (state == ST_L_FAST || state == ST_L_STOP || state == ST_L_CREEP))
         begin
            major_code <= ret_neg ? `ERR_LIMIT_UP : `ERR_LIMIT_LOW;
            SPEED_SEL  <= SPD_STOP;
            state      <= ST_HALT;
         end
      end
   end

   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);

   chk_bus_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
      |=> !AVS_WAITREQUEST) else $error("bus answer late");
   chk_done_refuse: assert property (start_req && state == ST_IDLE && done
      && (mode == MODE_STOPPER1 || mode == MODE_STOPPER2) && !err_clr
      |=> minor_code == `ERR_ALREADY_DONE && state == ST_IDLE)
      else $error("repeat request not refused");
   chk_dog_creep: assert property (accept && mode == MODE_STOPPER1 && DOG
      |=> SPEED_SEL == SPD_CREEP && !TORQUE_LIMIT_EN) else $error("dog start not at creep");
   chk_stop2_torque: assert property (accept && mode == MODE_STOPPER2
      |=> TORQUE_LIMIT_EN && SPEED_SEL == SPD_CREEP) else $error("stopper 2 start wrong");
   chk_torque_latch: assert property (state == ST_S_CREEP && TORQUE_LIMIT_EN
      && TORQUE_LIMITING && !torque_q |=> home_pos == $past(MOTOR_POS)
      && SPEED_SEL == SPD_STOP) else $error("home not latched on torque edge");
   chk_limit_cfg: assert property (start_req && state == ST_IDLE && mode == MODE_LIMIT
      && !lim_cfg |=> minor_code == `ERR_NO_LIMIT_CFG && state == ST_IDLE)
      else $error("missing limit config not refused");
   chk_scale_zset: assert property (start_req && state == ST_IDLE && mode == MODE_SCALE
      && z_set |=> minor_code == `ERR_Z_SETTING && state == ST_IDLE)
      else $error("z setting not refused");
   chk_opp_limit: assert property (opp_fall
      && (state == ST_L_FAST || state == ST_L_STOP || state == ST_L_CREEP)
      |=> major_code != `ERR_NONE && SPEED_SEL == SPD_STOP && !done)
      else $error("opposite limit not handled");
   chk_settle_gate: assert property ($rose(done) |-> $past(SERVO_SETTLED)
      && cur_pos == home_pos) else $error("completed without settling");
   chk_zero_flag: assert property (rev_begin && !ZERO_PULSE && !z_set
      |=> !zero_crossing_flag) else $error("zero flag not cleared on reverse");

endmodule

// ---- testbench/servo_axis_model.sv ----
// behavioural axis: amplifier, motor, hard stopper, dog, limit switches and zero marks
module servo_axis_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [1:0]  speed_sel,
   input  wire logic        dir_neg,
   input  wire logic        torque_en,
   output logic             dog,
   output logic             limit_up,
   output logic             limit_low,
   output logic             zero_pulse,
   output logic             torque_limiting,
   output logic             at_speed,
   output logic             stopped,
   output logic             settled,
   output logic [31:0]      motor_pos
);
   timeunit 1ns;
   timeprecision 100ps;
   // geometry, loaded by the bench while reset is held, except lim_low which keeps its default
   int start_pos = 100;
   int stop_pos  = 500;
   int dog_lo    = 300;
   int dog_hi    = 1000;
   int lim_up    = 2000;
   int lim_low   = 10;
   int pitch     = 32;
   int pos, vel, quiet, tgt, v, n;
   // commanded speed in position units per cycle
   assign tgt = speed_sel == 2'd2 ? 4 : (speed_sel == 2'd1 ? 1 : 0);
   // the profile ramps one unit per cycle, so a stop from return speed overshoots like a real axis
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         pos <= start_pos;
         vel <= 0;
         quiet <= 0;
         zero_pulse <= 1'b0;
      end else begin
         v = vel < tgt ? vel + 1 : (vel > tgt ? vel - 1 : vel);
         n = dir_neg ? pos - v : pos + v;
         if (!dir_neg && n > stop_pos)
            n = stop_pos;  // the stopper blocks travel whatever is commanded
         if (dir_neg)
            zero_pulse <= (pos - 1) / pitch != (n - 1) / pitch;
         else
            zero_pulse <= n / pitch != pos / pitch;
         vel <= v;
         pos <= n;
         quiet <= v == 0 ? quiet + 1 : 0;
      end
   end
   assign motor_pos       = 32'(pos);
   assign dog             = pos >= dog_lo && pos <= dog_hi;
   assign limit_up        = pos < lim_up;   // switch reads high while clear of the end
   assign limit_low       = pos > lim_low;
   assign torque_limiting = torque_en && pos == stop_pos;
   assign at_speed        = tgt != 0 && vel == tgt;
   assign stopped         = vel == 0;
   assign settled         = quiet >= 3;     // in-position lags standstill by a short settle
endmodule

// ---- testbench/home_return_sequencer_tb.sv ----
// self-checking bench for the homing sequencer against a behavioural axis
`include "home_return_defines.svh"
module home_return_sequencer_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk, sys_rst, avs_read, avs_write, avs_waitrequest;
   logic [7:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd, motor_pos;
   logic        dog, limit_up, limit_low, zero_pulse, torque_limiting;
   logic        at_speed, stopped, servo_settled, dir_neg, torque_limit_en;
   logic [1:0]  speed_sel, last_sel;
   int          miscompares = 0;
   int          comparisons = 0;
   int          pitch, creep_from;

   home_return_sequencer i_dut (.CLK(clk), .SYS_RST(sys_rst), .AVS_ADDRESS(avs_address),
      .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
      .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .DOG(dog),
      .LIMIT_UP(limit_up), .LIMIT_LOW(limit_low), .ZERO_PULSE(zero_pulse),
      .TORQUE_LIMITING(torque_limiting), .AT_SPEED(at_speed), .STOPPED(stopped),
      .SERVO_SETTLED(servo_settled), .MOTOR_POS(motor_pos), .SPEED_SEL(speed_sel),
      .DIR_NEG(dir_neg), .TORQUE_LIMIT_EN(torque_limit_en));
   servo_axis_model i_axis (.clk(clk), .rst(sys_rst), .speed_sel(speed_sel),
      .dir_neg(dir_neg), .torque_en(torque_limit_en), .dog(dog), .limit_up(limit_up),
      .limit_low(limit_low), .zero_pulse(zero_pulse), .torque_limiting(torque_limiting),
      .at_speed(at_speed), .stopped(stopped), .settled(servo_settled),
      .motor_pos(motor_pos));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic complete_run();
      if (miscompares == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_pins(input logic [3:0] got, input logic [3:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // one Avalon access, held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_write <= wr;
      avs_read <= !wr;
      avs_address <= a;
      avs_writedata <= d;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk_reg(rd, exp);
   endtask
   // polling is bounded so that a design that never finishes still reaches a verdict
   task automatic wait_reg(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] val);
      int i = 0;
      do begin
         bus(1'b0, a, 32'h0);
         i++;
      end while ((rd & mask) !== val && i < 4000);
      if ((rd & mask) !== val)
         miscompares++;  // polling ran out: counted, so a hang cannot end in a pass
   endtask
   // reset, lay out the axis, start homing and look at the first motion command
   task automatic run(input logic [4:0] cfg, input int st, lo, hi, stp, lup, p,
                      input logic [3:0] pins);
      sys_rst <= 1'b1;
      i_axis.start_pos = st;
      i_axis.dog_lo = lo;
      i_axis.dog_hi = hi;
      i_axis.stop_pos = stp;
      i_axis.lim_up = lup;
      i_axis.pitch = p;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      // a start is judged on the stored method, so the method is written first
      bus(1'b1, `REG_CTRL, {27'h0, cfg});
      bus(1'b1, `REG_CTRL, {23'h0, 1'b1, 3'h0, cfg});
      @(posedge clk);
      @(negedge clk);
      chk_pins({speed_sel, dir_neg, torque_limit_en}, pins);
   endtask
   // remember where creep begins; the expected zero mark is reckoned from there
   always @(negedge clk) begin
      if (speed_sel == 2'd1 && last_sel != 2'd1)
         creep_from = int'(motor_pos);
      last_sel = speed_sel;
   end
   initial begin
      repeat (60000) @(posedge clk);
      miscompares++;
      complete_run();
   end
   initial begin
      sys_rst = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 8'h00;
      avs_writedata = 32'h0;
      void'($urandom(32'h6211));
      pitch = 16 + int'($urandom % 32);
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      // every mapped register and one unmapped address read zero out of reset
      for (int a = 0; a <= 20; a += 4)
         expect_reg(8'(a), 32'h0);
      run(5'h00, 100 + int'($urandom % 50), 300, 1000, 500, 2000, pitch, 4'h8);
      wait_reg(`REG_STATUS, 32'h3, 32'h2);
      expect_reg(`REG_HOME_POS, 32'd500);
      expect_reg(`REG_CUR_POS, 32'd500);
      run(5'h00, 300 + int'($urandom % 100), 250, 1000, 500, 2000, pitch, 4'h4);
      wait_reg(`REG_STATUS, 32'h3, 32'h2);
      expect_reg(`REG_HOME_POS, 32'd500);
      run(5'h01, 100, 0, 0, 500, 2000, 100000, 4'h5);
      wait_reg(`REG_STATUS, 32'h3, 32'h2);
      expect_reg(`REG_CUR_POS, 32'd500);
      bus(1'b1, `REG_CTRL, 32'h101);
      @(posedge clk);
      @(negedge clk);
      chk_pins({speed_sel, dir_neg, torque_limit_en}, 4'h0);
      expect_reg(`REG_ERROR, `ERR_ALREADY_DONE);
      run(5'h02, 100, 0, 0, 100000, 600, pitch, 4'h0);
      expect_reg(`REG_ERROR, `ERR_NO_LIMIT_CFG);
      run(5'h0B, 100, 400, 460, 100000, 2000, pitch, 4'h0);
      expect_reg(`REG_ERROR, `ERR_Z_SETTING);
      run(5'h03, 100, 10, 20, 100000, 600, pitch, 4'h8);
      wait_reg(`REG_ERROR, 32'hFFFF, 32'hC9);
      expect_reg(`REG_ERROR, `ERR_NO_DOG);
      run(5'h12, 100, 0, 0, 100000, 600, 100000, 4'h8);
      wait_reg(`REG_ERROR, 32'hFFFF, 32'h78);
      expect_reg(`REG_ERROR, `ERR_NO_ZERO);
      run(5'h12, 100, 0, 0, 100000, 600, pitch, 4'h8);
      wait_reg(`REG_STATUS, 32'h3, 32'h2);
      expect_reg(`REG_HOME_POS, 32'((creep_from - 1) / pitch * pitch));
      run(5'h12, 700, 0, 0, 100000, 600, pitch, 4'h6);
      wait_reg(`REG_STATUS, 32'h3, 32'h2);
      expect_reg(`REG_HOME_POS, 32'((creep_from - 1) / pitch * pitch));
      run(5'h12, 100, 0, 0, 100000, 50, 100000, 4'h6);
      wait_reg(`REG_ERROR, 32'hFFFF_0000, 32'h044E_0000);
      expect_reg(`REG_ERROR, {`ERR_LIMIT_LOW, `ERR_NONE});
      run(5'h03, 100, 400, 460, 100000, 2000, pitch, 4'h8);
      wait_reg(`REG_STATUS, 32'h3, 32'h2);
      expect_reg(`REG_HOME_POS, 32'((creep_from + pitch) / pitch * pitch));
      run(5'h03, 420, 400, 460, 100000, 2000, pitch, 4'hA);
      wait_reg(`REG_STATUS, 32'h3, 32'h2);
      expect_reg(`REG_HOME_POS, 32'((creep_from + pitch) / pitch * pitch));
      complete_run();
   end
endmodule
